// file: hdl/hpw_pkg.sv
// Types shared by the hashed page table walker
`default_nettype none
package hpw_pkg;
  // Walker states, Gray coded along idle-region-translate-read-tag-insert
  typedef enum logic [2:0] {
    HPW_IDLE  = 3'h0,
    HPW_RGN   = 3'h1,
    HPW_XLAT  = 3'h3,
    HPW_RD0   = 3'h2,
    HPW_RDTAG = 3'h6,
    HPW_INS   = 3'h7,
    HPW_TFLT  = 3'h5,
    HPW_FAULT = 3'h4
  } hpw_state_t;

  // Fault vectors delivered to the core
  typedef enum logic [2:0] {
    HPW_FK_INSTR_MISS = 3'h0,
    HPW_FK_DATA_MISS  = 3'h1,
    HPW_FK_INSTR_ALT  = 3'h2,
    HPW_FK_DATA_ALT   = 3'h3,
    HPW_FK_INSTR_TBL  = 3'h4,
    HPW_FK_DATA_TBL   = 3'h5
  } hpw_fault_t;
endpackage
`default_nettype wire

// file: hdl/hpw_region_file.sv
// Region register file: eight entries with registered read data
`include "hpw_regs.svh"
`default_nettype none
module hpw_region_file (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [2:0]  rd_idx,
  output logic      [31:0] rd_data
);
  logic [31:0] mem [`HPW_RGN_COUNT];

  // One writable entry per region
  genvar g;
  generate
    for (g = 0; g < `HPW_RGN_COUNT; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[g] <= `HPW_RGN_RESET;
        end else if (wr_en && wr_idx == 3'(g)) begin
          mem[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read keeps the lookup off the hash path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= `HPW_RGN_RESET;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule
`default_nettype wire

// file: hdl/hpw_regs.svh
// Constants for the hashed page table walker: field positions, layouts and offsets
// Summary of operation
// - Short mode reads a linear per-region table of 8-byte entries, one per page.
// - Long mode reads a hashed table of 32-byte entries holding a subset.
// - Short entry address ignores the region identifier; short entries carry no key.
// - Long hash and tag both include the region identifier.
// - Long hash uses the preferred page size of the faulting region.
// - Table accesses use translated virtual addresses and can miss.
// - Walker table miss raises table fault with original and table addresses.
// - Bytes 24-31 of a long entry are never read by the walker.
// - Long tag sits at bytes 16-23; mismatch refuses the insert.
// - First 8 entry bytes are inserted unchanged in insertion format.
// - A global purge makes earlier table writes visible to later walks.
// - Abort, tag mismatch, malformed entry or absent walker raise a miss fault.
// - Instruction and data misses use two distinct fault vectors.
// - Miss fault loads the hashed address register with the table address.
// - Miss fault presets insertion info key and page size from region register.
// - Miss fault loads fault address with bundle or data reference address.
// - All table references go through the data translation cache.
`ifndef HPW_REGS_SVH
`define HPW_REGS_SVH

// Region register entry layout, eight regions selected by address bits 63:61
`define HPW_RGN_COUNT     8
`define HPW_RGN_EN_BIT    31
`define HPW_RGN_LONG_BIT  30
`define HPW_RGN_PS_MSB    29
`define HPW_RGN_PS_LSB    24
`define HPW_RGN_RID_MSB   23
`define HPW_RGN_RID_LSB   0
`define HPW_RGN_RESET     32'h0000_0000

// Entry geometry
`define HPW_SHORT_SHIFT   3
`define HPW_LONG_SHIFT    5
`define HPW_TAG_OFFSET    64'h0000_0000_0000_0010
`define HPW_TAG_INV_BIT   63

// Entry word 0: present bit and bits that must be zero
`define HPW_PTE_P_BIT     0
`define HPW_PTE_RSVD_MASK 64'hFFF0_0000_0000_0002

// Insertion information register layout
`define HPW_II_KEY_MSB    31
`define HPW_II_KEY_LSB    8
`define HPW_II_PS_MSB     7
`define HPW_II_PS_LSB     2
`define HPW_II_RESET      64'h0000_0000_0000_0000

`endif

// file: hdl/hpw_walker.sv
// Hashed page table walker with miss and table-translation fault presets
`include "hpw_regs.svh"
`default_nettype none
module hpw_walker import hpw_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        walker_present,
  input  wire logic [63:0] table_base,
  input  wire logic [5:0]  table_size_log,
  input  wire logic        rgn_wr_en,
  input  wire logic [2:0]  rgn_wr_idx,
  input  wire logic [31:0] rgn_wr_data,
  input  wire logic        miss_valid,
  output logic             miss_ready,
  input  wire logic        miss_is_instr,
  input  wire logic [63:0] miss_vaddr,
  input  wire logic        walk_abort,
  input  wire logic        purge_global,
  output logic             dtc_req,
  output logic      [63:0] dtc_vaddr,
  input  wire logic        dtc_done,
  input  wire logic        dtc_hit,
  input  wire logic [63:0] dtc_paddr,
  output logic             mem_rd_req,
  output logic      [63:0] mem_rd_addr,
  input  wire logic        mem_rd_ack,
  input  wire logic [63:0] mem_rd_data,
  output logic             fill_valid,
  output logic             fill_is_instr,
  output logic      [63:0] fill_data,
  output logic      [63:0] fill_info,
  output logic             fault_valid,
  output logic      [2:0]  fault_kind,
  output logic      [63:0] fault_address_reg,
  output logic      [63:0] hashed_address_reg,
  output logic      [63:0] insertion_info_reg
);
  hpw_state_t  state;
  hpw_fault_t  kind;
  logic        is_instr;
  logic [63:0] vaddr;
  logic [31:0] rgn;
  logic [31:0] rgn_rdata;
  logic [2:0]  rgn_rd_idx;
  logic [63:0] tbl_addr;
  logic [63:0] tbl_paddr;
  logic [62:0] tag_exp;
  logic [63:0] entry0;
  logic [60:0] vpn;
  logic [63:0] size_mask;
  logic [63:0] next_tbl_addr;
  logic [62:0] next_tag;
  logic        long_fmt;
  logic        pte_ok;
  logic        tag_ok;
  logic        walking;

  // Region register file, read by the faulting region or the table's region
  hpw_region_file u_rgn (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (rgn_wr_en),
    .wr_idx  (rgn_wr_idx),
    .wr_data (rgn_wr_data),
    .rd_idx  (rgn_rd_idx),
    .rd_data (rgn_rdata)
  );

  // Table miss looks up the region of the table address for its fault preset
  assign rgn_rd_idx = (state == HPW_IDLE) ? miss_vaddr[63:61] : tbl_addr[63:61];

  // Hash and tag; short mode never looks at the region identifier
  assign vpn       = rgn_rdata[`HPW_RGN_EN_BIT] ? (vaddr[60:0] >> rgn_rdata[29:24]) : 61'h0;
  assign size_mask = (64'h1 << table_size_log) - 64'h1;
  always_comb begin
    if (rgn_rdata[`HPW_RGN_LONG_BIT]) begin
      next_tbl_addr = table_base + ((({3'h0, vpn} ^ {40'h0, rgn_rdata[23:0]})
                      << `HPW_LONG_SHIFT) & size_mask);
    end else begin
      next_tbl_addr = {vaddr[63:61],
                       61'(table_base[60:0] + (vpn << `HPW_SHORT_SHIFT))};
    end
  end
  assign next_tag = {rgn_rdata[23:0], 39'h0} ^ {2'h0, vpn};

  assign long_fmt = rgn[`HPW_RGN_LONG_BIT];
  assign walking  = (state != HPW_IDLE) && (state != HPW_FAULT) && (state != HPW_TFLT);
  // Malformed entries never reach the cache
  assign pte_ok   = entry0[`HPW_PTE_P_BIT] && ((entry0 & `HPW_PTE_RSVD_MASK) == 64'h0);
  // A set tag-invalid bit means an update is in flight, so it never matches
  assign tag_ok   = !mem_rd_data[`HPW_TAG_INV_BIT] && (mem_rd_data[62:0] == tag_exp);

  // Walk sequencer; abort beats purge, purge restarts the table access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= HPW_IDLE;
    end else if (walk_abort && walking && state != HPW_IDLE) begin
      state <= HPW_FAULT;
    end else begin
      unique case (state)
        HPW_IDLE: begin
          if (miss_valid) begin
            state <= HPW_RGN;
          end
        end
        HPW_RGN: begin
          if (!rgn_rdata[`HPW_RGN_EN_BIT] || !walker_present) begin
            state <= HPW_FAULT;
          end else begin
            state <= HPW_XLAT;
          end
        end
        HPW_XLAT: begin
          if (dtc_done) begin
            state <= dtc_hit ? HPW_RD0 : HPW_TFLT;
          end
        end
        HPW_RD0: begin
          if (purge_global) begin
            state <= HPW_XLAT;
          end else if (mem_rd_ack) begin
            state <= long_fmt ? HPW_RDTAG : HPW_INS;
          end
        end
        HPW_RDTAG: begin
          if (purge_global) begin
            state <= HPW_XLAT;
          end else if (mem_rd_ack) begin
            state <= tag_ok ? HPW_INS : HPW_FAULT;
          end
        end
        HPW_INS: begin
          state <= pte_ok ? HPW_IDLE : HPW_FAULT;
        end
        HPW_TFLT: begin
          state <= HPW_FAULT;
        end
        HPW_FAULT: begin
          state <= HPW_IDLE;
        end
      endcase
    end
  end

  // Capture the miss and the region entry that governs it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vaddr    <= 64'h0;
      is_instr <= 1'b0;
      rgn      <= `HPW_RGN_RESET;
      tbl_addr <= 64'h0;
      tag_exp  <= 63'h0;
    end else if (state == HPW_IDLE && miss_valid) begin
      vaddr    <= miss_vaddr;
      is_instr <= miss_is_instr;
    end else if (state == HPW_RGN) begin
      rgn      <= rgn_rdata;
      tbl_addr <= next_tbl_addr;
      tag_exp  <= next_tag;
    end
  end

  // Translated table address and first entry word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbl_paddr <= 64'h0;
      entry0    <= 64'h0;
    end else if (state == HPW_XLAT && dtc_done && dtc_hit) begin
      tbl_paddr <= dtc_paddr;
    end else if (state == HPW_RD0 && mem_rd_ack && !purge_global) begin
      entry0    <= mem_rd_data;
    end
  end

  // Fault vector choice: disabled region goes to software, table translation miss to the table vector, else a miss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kind <= HPW_FK_INSTR_MISS;
    end else if (state == HPW_RGN) begin
      if (!rgn_rdata[`HPW_RGN_EN_BIT]) begin
        kind <= is_instr ? HPW_FK_INSTR_ALT : HPW_FK_DATA_ALT;
      end else begin
        kind <= is_instr ? HPW_FK_INSTR_MISS : HPW_FK_DATA_MISS;
      end
    end else if (state == HPW_XLAT && dtc_done && !dtc_hit) begin
      kind <= is_instr ? HPW_FK_INSTR_TBL : HPW_FK_DATA_TBL;
    end
  end

  // Fault presets: addresses are ready at the fault cycle, and the key
  // comes from the region of the address that missed, or for a table fault from the table address's region
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_address_reg  <= 64'h0;
      hashed_address_reg <= 64'h0;
      insertion_info_reg <= `HPW_II_RESET;
    end else if (state == HPW_RGN) begin
      fault_address_reg  <= vaddr;
      hashed_address_reg <= next_tbl_addr;
      insertion_info_reg <= {32'h0, rgn_rdata[23:0], rgn_rdata[29:24], 2'h0};
    end else if (state == HPW_TFLT) begin
      insertion_info_reg <= {32'h0, rgn_rdata[23:0], rgn_rdata[29:24], 2'h0};
    end
  end

  // Handshakes; table references only ever use the data cache
  assign miss_ready  = (state == HPW_IDLE);
  assign dtc_req     = (state == HPW_XLAT) && !walk_abort;
  assign dtc_vaddr   = tbl_addr;
  assign mem_rd_req  = ((state == HPW_RD0) || (state == HPW_RDTAG)) && !walk_abort;
  // Only word 0 and the tag word are fetched; the link word stays untouched
  assign mem_rd_addr = (state == HPW_RDTAG) ? tbl_paddr + `HPW_TAG_OFFSET : tbl_paddr;
  // Single-cycle insert after every check, so a failed walk inserts nothing
  assign fill_valid      = (state == HPW_INS) && pte_ok && !walk_abort;
  assign fill_is_instr   = is_instr;
  assign fill_data       = entry0;
  assign fill_info       = {32'h0, rgn[23:0], rgn[29:24], 2'h0};
  assign fault_valid     = (state == HPW_FAULT);
  assign fault_kind      = kind;

  // Checks on the walker's own outputs
  a_no_partial_ins: assert property (@(posedge clk) disable iff (rst)
    walk_abort |-> !fill_valid)
    else $error("insert during abort");
  a_vector_split: assert property (@(posedge clk) disable iff (rst)
    fault_valid |-> (fault_kind[0] == !is_instr))
    else $error("fault vector does not match access type");
  a_tbl_fault_regs: assert property (@(posedge clk) disable iff (rst)
    (state == HPW_XLAT && dtc_done && !dtc_hit && !walk_abort) |-> ##2
    (fault_valid && fault_address_reg == vaddr && hashed_address_reg == dtc_vaddr))
    else $error("table fault registers wrong");
  a_short_stride: assert property (@(posedge clk) disable iff (rst)
    (dtc_req && !long_fmt) |-> (dtc_vaddr[2:0] == 3'h0))
    else $error("short entry address not 8-byte aligned");
  a_long_stride: assert property (@(posedge clk) disable iff (rst)
    (dtc_req && long_fmt && table_base[4:0] == 5'h0) |-> (dtc_vaddr[4:0] == 5'h0))
    else $error("long entry address not 32-byte aligned");
  a_tag_mismatch: assert property (@(posedge clk) disable iff (rst)
    (state == HPW_RDTAG && mem_rd_ack && !tag_ok && !walk_abort && !purge_global)
    |=> (fault_valid && !fill_valid))
    else $error("tag mismatch did not fault");
  a_ins_word0: assert property (@(posedge clk) disable iff (rst)
    (state == HPW_RD0 && mem_rd_ack && !purge_global && !walk_abort && !long_fmt)
    |=> (state == HPW_INS && fill_data == $past(mem_rd_data)))
    else $error("inserted data differs from entry word 0");
  a_disabled_alt: assert property (@(posedge clk) disable iff (rst)
    (state == HPW_RGN && !rgn_rdata[`HPW_RGN_EN_BIT] && !walk_abort)
    |=> (fault_valid && (fault_kind == HPW_FK_INSTR_ALT || fault_kind == HPW_FK_DATA_ALT)))
    else $error("disabled region did not go to software");
  a_key_preset: assert property (@(posedge clk) disable iff (rst)
    (fault_valid && fault_kind < 3'(HPW_FK_INSTR_TBL))
    |-> (insertion_info_reg[`HPW_II_KEY_MSB:`HPW_II_KEY_LSB] == rgn[23:0]
         && insertion_info_reg[`HPW_II_PS_MSB:`HPW_II_PS_LSB] == rgn[29:24]))
    else $error("insertion info preset wrong");
  a_miss_addrs: assert property (@(posedge clk) disable iff (rst)
    (fault_valid && fault_kind < 3'(HPW_FK_INSTR_ALT))
    |-> (hashed_address_reg == tbl_addr && fault_address_reg == vaddr))
    else $error("miss fault addresses wrong");
  a_purge_rewalk: assert property (@(posedge clk) disable iff (rst)
    (purge_global && !walk_abort && (state == HPW_RD0 || state == HPW_RDTAG))
    |=> (state == HPW_XLAT && dtc_req))
    else $error("purge did not restart the table access");

  // Table faults take their key from the table's own region, which may differ
  a_tbl_key_preset: assert property (@(posedge clk) disable iff (rst)
    (fault_valid && fault_kind >= 3'(HPW_FK_INSTR_TBL))
    |-> (insertion_info_reg[`HPW_II_KEY_MSB:`HPW_II_KEY_LSB]
         == u_rgn.mem[tbl_addr[63:61]][`HPW_RGN_RID_MSB:`HPW_RGN_RID_LSB]))
    else $error("table fault key not from the table region");
  // A table access that misses must not go on to read memory
  a_tbl_miss_noread: assert property (@(posedge clk) disable iff (rst)
    (state == HPW_XLAT && dtc_done && !dtc_hit) |=> (!mem_rd_req && !fill_valid))
    else $error("memory read after table translation miss");
  // Answers are single-cycle pulses and the walker is idle right after them
  a_fill_pulse: assert property (@(posedge clk) disable iff (rst)
    fill_valid |=> (!fill_valid && miss_ready))
    else $error("insert held longer than one cycle");
  a_fault_pulse: assert property (@(posedge clk) disable iff (rst)
    fault_valid |=> (!fault_valid && miss_ready))
    else $error("fault held longer than one cycle");
  // With an aligned entry the link word offset never shows on the address
  a_link_unread: assert property (@(posedge clk) disable iff (rst)
    (mem_rd_req && tbl_paddr[4:0] == 5'h0) |-> (mem_rd_addr[4:3] != 2'h3))
    else $error("walker addressed the link word");
  a_long_tag_first: assert property (@(posedge clk) disable iff (rst)
    (fill_valid && long_fmt) |-> ($past(state) == HPW_RDTAG))
    else $error("long entry inserted without a tag check");
  a_absent_walker: assert property (@(posedge clk) disable iff (rst)
    (state == HPW_RGN && rgn_rdata[`HPW_RGN_EN_BIT] && !walker_present && !walk_abort)
    |=> (fault_valid && fault_kind < 3'(HPW_FK_INSTR_ALT)))
    else $error("absent walker did not raise a miss fault");

  // Main scenarios: long insert, table fault, software vector, purge, bad entry
  c_insert:    cover property (@(posedge clk) disable iff (rst) fill_valid && long_fmt);
  c_tbl_fault: cover property (@(posedge clk) disable iff (rst)
    fault_valid && fault_kind == HPW_FK_DATA_TBL);
  c_alt:       cover property (@(posedge clk) disable iff (rst)
    fault_valid && fault_kind == HPW_FK_INSTR_ALT);
  c_purge:     cover property (@(posedge clk) disable iff (rst)
    purge_global && state == HPW_RD0);
  c_bad_entry: cover property (@(posedge clk) disable iff (rst)
    state == HPW_INS && !pte_ok);
endmodule
`default_nettype wire

// file: verif/hashed_page_walker_miss_faults_tb.sv
// Self-checking bench for the hashed page table walker and its miss faults
`default_nettype none
`include "hpw_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module hashed_page_walker_miss_faults_tb import hpw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] VS  = 64'h2000_0000_1234_5678;
  localparam logic [63:0] VL  = 64'h4000_0000_00AB_C000;
  localparam logic [63:0] VD  = 64'h6000_0000_0000_1000;
  localparam logic [63:0] PTE = 64'h0000_0000_0123_4561;
  localparam logic [23:0] RS  = 24'h01_2345;
  localparam logic [23:0] RL  = 24'h00_ABCD;
  localparam logic [63:0] IS  = {32'h0, RS, 6'h0C, 2'h0};
  localparam logic [2:0]  FK [6] = '{HPW_FK_DATA_MISS, HPW_FK_DATA_TBL, HPW_FK_INSTR_TBL,
                                     HPW_FK_DATA_MISS, HPW_FK_INSTR_MISS, HPW_FK_DATA_MISS};
  logic        clk, rst, walker_present, rgn_wr_en, miss_valid, miss_is_instr, walk_abort;
  logic        purge_global, xlat_miss, miss_ready, dtc_req, dtc_done, dtc_hit, mem_rd_req;
  logic        mem_rd_ack, fill_valid, fill_is_instr, fault_valid, got_ins, got_flt;
  logic [2:0]  rgn_wr_idx, fault_kind;
  logic [3:0]  lat;
  logic [5:0]  table_size_log;
  logic [31:0] rgn_wr_data;
  logic [63:0] table_base, miss_vaddr, dtc_vaddr, dtc_paddr, mem_rd_addr, mem_rd_data;
  logic [63:0] fill_data, fill_info, fault_address_reg, hashed_address_reg;
  logic [63:0] insertion_info_reg, ta, pa, tg;
  int          miscompares, checked, nd, nr;

  hpw_walker i_dut (.*);
  hpw_mem_model i_mem (.*);

  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Region entry: enable, long format, preferred page size, region id
  task automatic set_rgn(input logic [2:0] i, input logic [31:0] d);
    @(negedge clk);
    rgn_wr_en = 1'b1;
    rgn_wr_idx = i;
    rgn_wr_data = d;
    @(negedge clk);
    rgn_wr_en = 1'b0;
  endtask

  // One miss; abort or purge can be raised a set number of cycles after it is taken
  task automatic walk(input logic ins, input logic [63:0] va, input int ab, input int pg);
    int n;
    @(negedge clk);
    miss_valid = 1'b1;
    miss_is_instr = ins;
    miss_vaddr = va;
    @(negedge clk);
    miss_valid = 1'b0;
    for (n = 0; n < 200; n++) begin
      got_ins = (fill_valid === 1'b1);
      got_flt = (fault_valid === 1'b1);
      if (got_ins || got_flt) break;
      walk_abort = (ab >= 0 && n >= ab);
      purge_global = (n == pg);
      @(negedge clk);
    end
    walk_abort = 1'b0;
    purge_global = 1'b0;
    if (!got_ins && !got_flt) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // Outcome of a walk: insert with its payload, or fault with its presets
  task automatic chk(input logic ins, input logic [2:0] k, input logic [63:0] va, ih, ii);
    `CHK(got_ins, ins)
    `CHK(got_flt, !ins)
    if (ins) begin
      `CHK(fill_is_instr, miss_is_instr)
      `CHK(fill_data, PTE)
      `CHK(fill_info, ii)
    end else begin
      `CHK(fault_kind, k)
      `CHK(fault_address_reg, va)
      if (ih !== 64'h0) `CHK(hashed_address_reg, ih)
      `CHK(insertion_info_reg, ii)
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Reset, program regions, then walk each path; inputs move on falling edges
  initial begin
    rst = 1'b1;
    {walker_present, rgn_wr_en, miss_valid, miss_is_instr, walk_abort} = 5'h10;
    {purge_global, xlat_miss, rgn_wr_idx, lat, rgn_wr_data} = '0;
    table_base = 64'h2000_0000_0040_0000;
    table_size_log = 6'h10;
    miss_vaddr = 64'h0;
    repeat (16) @(negedge clk);
    `CHK(miss_ready, 1'b1)
    `CHK(fault_valid, 1'b0)
    rst = 1'b0;
    set_rgn(3'h2, {2'h3, 6'h0E, RL});
    set_rgn(3'h3, {2'h0, 6'h0D, 24'h00_0077});
    ta = {VS[63:61], table_base[60:0] + ((VS[60:0] >> 12) << 3)};
    pa = ta + i_mem.PA_OFS;
    i_mem.mem[pa] = PTE;
    // Short hits under two region ids must land on the same entry
    for (int i = 0; i < 2; i++) begin
      set_rgn(3'h1, {2'h2, 6'h0C, i ? RS : 24'h0F_0F0F});
      nr = i_mem.n_rd;
      walk(1'b0, VS, -1, -1);
      chk(1'b1, 3'h0, VS, ta, {32'h0, i ? RS : 24'h0F_0F0F, 6'h0C, 2'h0});
      `CHK(i_mem.va_last, ta)
      `CHK(i_mem.n_rd - nr, 1)
    end
    // Malformed entry, table misses, no walker, and an abort while translating
    for (int c = 0; c < 6; c++) begin
      i_mem.mem[pa] = (c == 0) ? PTE | 64'h2 : PTE;
      xlat_miss = (c == 1 || c == 2);
      walker_present = !(c == 3 || c == 4);
      lat = (c == 5) ? 4'h3 : 4'h0;
      walk(c == 2 || c == 4, VS, (c == 5) ? 3 : -1, -1);
      chk(1'b0, FK[c], VS, ta, IS);
    end
    // Purge during the slow entry read restarts translation, then inserts
    nd = i_mem.n_dtc;
    walk(1'b0, VS, -1, 6);
    chk(1'b1, 3'h0, VS, ta, IS);
    `CHK(i_mem.n_dtc - nd, 2)
    // Region with the walker off goes straight to the software vectors
    for (int i = 0; i < 2; i++) begin
      walk(i[0], VD, -1, -1);
      chk(1'b0, i ? HPW_FK_INSTR_ALT : HPW_FK_DATA_ALT, VD, 64'h0,
          {32'h0, 24'h00_0077, 6'h0D, 2'h0});
    end
    // Long format: good tag, wrong tag, tag marked invalid; link word never read
    ta = table_base + (((({3'h0, VL[60:0] >> 14}) ^ {40'h0, RL}) << 5) & 64'hFFFF);
    tg = {1'b0, {RL, 39'h0} ^ {2'h0, VL[60:0] >> 14}};
    pa = ta + i_mem.PA_OFS;
    i_mem.mem[pa] = PTE;
    i_mem.mem[pa + 64'h18] = 64'h0000_0000_0000_DEAD;
    for (int i = 0; i < 3; i++) begin
      i_mem.mem[pa + 64'h10] = tg ^ ((i == 1) ? 64'h1 : 64'h0);
      if (i == 2) i_mem.mem[pa + 64'h10][63] = 1'b1;
      nr = i_mem.n_rd;
      walk(1'b1, VL, -1, -1);
      chk(i == 0, HPW_FK_INSTR_MISS, VL, ta, {32'h0, RL, 6'h0E, 2'h0});
      `CHK(i_mem.va_last, ta)
      `CHK(i_mem.n_rd - nr, 2)
      `CHK(i_mem.rd_last, pa + 64'h10)
    end
    // Long table miss: key and page size come from the table's region, not the miss's
    xlat_miss = 1'b1;
    walk(1'b0, VL, -1, -1);
    chk(1'b0, HPW_FK_DATA_TBL, VL, ta, IS);
    xlat_miss = 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire

// file: verif/hpw_mem_model.sv
// Partner model: data translation cache and table memory behind the walker
`default_nettype none
module hpw_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  lat,
  input  wire logic        xlat_miss,
  input  wire logic        dtc_req,
  input  wire logic [63:0] dtc_vaddr,
  output logic             dtc_done,
  output logic             dtc_hit,
  output logic      [63:0] dtc_paddr,
  input  wire logic        mem_rd_req,
  input  wire logic [63:0] mem_rd_addr,
  output logic             mem_rd_ack,
  output logic      [63:0] mem_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] PA_OFS = 64'h0000_0100_0000_0000;
  logic [63:0] mem [logic [63:0]];
  logic [3:0]  dcnt, mcnt;
  logic [63:0] va_last, rd_last;
  int          n_dtc, n_rd;

  // Answers launch between edges and last one cycle; released data is inverted every cycle
  // so that a walker sampling an odd number of cycles late never sees a stale but plausible value
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      {dtc_done, dtc_hit, mem_rd_ack, dcnt, mcnt} <= '0;
      {dtc_paddr, mem_rd_data} <= '0;
    end else begin
      {dtc_done, dtc_hit, mem_rd_ack} <= 3'h0;
      dtc_paddr <= ~dtc_paddr;
      mem_rd_data <= ~mem_rd_data;
      dcnt <= (dtc_req && !dtc_done && dcnt < lat) ? dcnt + 4'h1 : 4'h0;
      mcnt <= (mem_rd_req && !mem_rd_ack && mcnt < lat) ? mcnt + 4'h1 : 4'h0;
      if (dtc_req && !dtc_done && dcnt == lat) begin
        dtc_done <= 1'b1;
        dtc_hit <= !xlat_miss;
        dtc_paddr <= dtc_vaddr + PA_OFS;
        va_last <= dtc_vaddr;
        n_dtc <= n_dtc + 1;
      end
      if (mem_rd_req && !mem_rd_ack && mcnt == lat) begin
        mem_rd_ack <= 1'b1;
        mem_rd_data <= mem.exists(mem_rd_addr) ? mem[mem_rd_addr] : ~mem_rd_addr;
        rd_last <= mem_rd_addr;
        n_rd <= n_rd + 1;
      end
    end
  end
endmodule
`default_nettype wire
